// File: touch_key_pkg.sv
// Constants and register map of the touch-key status and tuning block
// ==========================================================================
// How it works
// - Two bytes carry sixteen key detect bits
// - Status byte change pulls change line low
// - Slider position held as read-only byte
// - Input pins 1-3 in bits 2-4, outputs zero
// - Input pins sampled once per 16 ms
// - Read-only sub-revision byte
// - Non-zero write starts recalibration of keys
// - Non-zero write resets device to defaults
// - Stop acking, release change, then reset
// - Sleep interval value times 16 ms
// - Sleep interval zero stops all measurements
// - Sleep interval resets to one
// - Burst repeat low six bits, host avoids zero
// - Reference tracks slowly only outside detection
// - Slew-limited reference steps trigger threshold recompute
// - Drift rate seven bits, 0.16 s per step
// - Drift rate zero disables that direction
// - Drift rates reset to 20 and 5
// - Per-key counter counts over-threshold acquisitions
// - Below-threshold acquisition clears the counter
// - Integrator limit five bits, needs limit plus one
// - Change released after host reads changed bytes
// - Change output is active-low open drain
package touch_key_pkg;

   // ========================================================================
   // Register offsets
   localparam logic [7:0] REG_KEY_LO = 8'h03;
   localparam logic [7:0] REG_KEY_HI = 8'h04;
   localparam logic [7:0] REG_SLIDER = 8'h05;
   localparam logic [7:0] REG_INPUTS = 8'h06;
   localparam logic [7:0] REG_SUBREV = 8'h07;
   localparam logic [7:0] REG_RECAL = 8'h0a;
   localparam logic [7:0] REG_SOFT_RST = 8'h0b;
   localparam logic [7:0] REG_SLEEP = 8'h0c;
   localparam logic [7:0] REG_BURST = 8'h0d;
   localparam logic [7:0] REG_NEG_RATE = 8'h0f;
   localparam logic [7:0] REG_POS_RATE = 8'h10;
   localparam logic [7:0] REG_LIMIT = 8'h11;
   localparam logic [7:0] REG_LAST = 8'hff;

   // ========================================================================
   // Field widths and positions
   localparam int BURST_W = 6;
   localparam int RATE_W = 7;
   localparam int LIMIT_W = 5;
   localparam int DI_W = 6;
   localparam int KEYS = 16;
   localparam int GPIO_N = 3;
   localparam int GPIO_LSB = 2;

   // ========================================================================
   // Reset values
   localparam logic [7:0] SLEEP_RST = 8'h01;
   localparam logic [BURST_W-1:0] BURST_RST = 6'h01;
   localparam logic [RATE_W-1:0] NEG_RATE_RST = 7'h14;
   localparam logic [RATE_W-1:0] POS_RATE_RST = 7'h05;
   localparam logic [LIMIT_W-1:0] LIMIT_RST = 5'h03;

   // Identity values, arbitrary
   localparam logic [7:0] SUB_REVISION = 8'h00;
   localparam logic [4:0] DEV_ADDR_HI = 5'h03;

   // ========================================================================
   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CYCLE_MS = 16;
   localparam int TRACK_UNIT_MS = 160;
   localparam int CYCLE_CLKS = (CYCLE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   localparam int TRACK_DIV = TRACK_UNIT_MS / CYCLE_MS;

   // ========================================================================
   // Serial slave and soft-reset states
   typedef enum logic [2:0] {
      I_IDLE,
      I_RX,
      I_ACK,
      I_TX,
      I_HACK
   } link_state_type;

   typedef enum logic [1:0] {
      STG_DEV,
      STG_REG,
      STG_DATA
   } byte_stage_type;

   typedef enum logic [1:0] {
      RS_NONE,
      RS_ARMED,
      RS_BLOCK
   } soft_reset_type;

endpackage : touch_key_pkg

// File: touch_key_status_and_tuning.sv
// Touch-key status, tuning registers and serial register access
`timescale 1ns/10ps
`default_nettype none

module touch_key_status_and_tuning
   import touch_key_pkg::*;
#(
   parameter int unsigned CYCLE_CLKS_P = CYCLE_CLKS
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Serial register link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] addr_sel_i,
   // Change notification pin
   output logic change_n_o,
   output logic change_oe_o,
   // Acquisition results
   input wire logic acq_done_i,
   input wire logic [KEYS-1:0] key_over_thr_i,
   input wire logic [KEYS-1:0] key_above_ref_i,
   input wire logic [KEYS-1:0] key_below_ref_i,
   input wire logic [7:0] slider_pos_i,
   // General-purpose pins
   input wire logic [GPIO_N-1:0] gpio_level_i,
   input wire logic [GPIO_N-1:0] gpio_is_output_i,
   // Measurement control
   output logic meas_start_o,
   output logic low_power_o,
   output logic [BURST_W-1:0] burst_repeat_count_o,
   output logic recal_start_o,
   output logic [KEYS-1:0] ref_up_o,
   output logic [KEYS-1:0] ref_down_o
);

   // ========================================================================
   // State
   typedef struct packed {
      logic [31:0] cyc_cnt;
      logic [7:0] sleep_cnt;
      logic [3:0] track_div;
      logic [RATE_W-1:0] neg_cnt;
      logic [RATE_W-1:0] pos_cnt;
      soft_reset_type rst_stage;
      // Serial slave
      link_state_type ist;
      byte_stage_type stage;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic rw;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      // Registers
      logic [7:0] recal;
      logic [7:0] soft_rst;
      logic [7:0] sleep;
      logic [BURST_W-1:0] burst;
      logic [RATE_W-1:0] neg_rate;
      logic [RATE_W-1:0] pos_rate;
      logic [LIMIT_W-1:0] limit;
      // Status
      logic [KEYS-1:0] detect;
      logic [KEYS-1:0][DI_W-1:0] di_cnt;
      logic [7:0] slider;
      logic [GPIO_N-1:0] gpio;
      logic [3:0] changed;
      // Pulsed outputs
      logic meas_start;
      logic recal_start;
      logic [KEYS-1:0] ref_up;
      logic [KEYS-1:0] ref_down;
   } state_type;

   state_type q;
   state_type n;

   logic cycle_tick;
   logic track_tick;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic blocking;
   logic neg_step;
   logic pos_step;
   logic [6:0] dev_addr;
   logic [DI_W-1:0] need;
   logic [KEYS-1:0] det_next;
   logic [7:0] rd;

   // ========================================================================
   // Defaults after power-on or commanded reset
   function automatic state_type reset_state();
      state_type s;
      s = '0;
      s.rst_stage = RS_NONE;
      s.ist = I_IDLE;
      s.stage = STG_DEV;
      s.scl_q = 1'b1;
      s.sda_q = 1'b1;
      s.sleep = SLEEP_RST;
      s.burst = BURST_RST;
      s.neg_rate = NEG_RATE_RST;
      s.pos_rate = POS_RATE_RST;
      s.limit = LIMIT_RST;
      return s;
   endfunction : reset_state

   // Register read decode
   function automatic logic [7:0] reg_read(input logic [7:0] a, input state_type s);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         REG_KEY_LO: v = s.detect[7:0];
         REG_KEY_HI: v = s.detect[15:8];
         REG_SLIDER: v = s.slider;
         REG_INPUTS: v = {3'h0, s.gpio, 2'h0};
         REG_SUBREV: v = SUB_REVISION;
         REG_RECAL: v = s.recal;
         REG_SOFT_RST: v = s.soft_rst;
         REG_SLEEP: v = s.sleep;
         REG_BURST: v = {2'h0, s.burst};
         REG_NEG_RATE: v = {1'b0, s.neg_rate};
         REG_POS_RATE: v = {1'b0, s.pos_rate};
         REG_LIMIT: v = {3'h0, s.limit};
         default: v = 8'h00;
      endcase
      return v;
   endfunction : reg_read

   // ========================================================================
   // Next-state logic
   always_comb begin
      n = q;
      n.meas_start = 1'b0;
      n.recal_start = 1'b0;
      n.ref_up = '0;
      n.ref_down = '0;
      n.scl_q = scl_i;
      n.sda_q = sda_i;
      cycle_tick = (q.cyc_cnt == 32'(CYCLE_CLKS_P - 1));
      n.cyc_cnt = cycle_tick ? 32'h0 : q.cyc_cnt + 32'h1;
      scl_rise = scl_i & ~q.scl_q;
      scl_fall = ~scl_i & q.scl_q;
      start_c = q.scl_q & scl_i & q.sda_q & ~sda_i;
      stop_c = q.scl_q & scl_i & ~q.sda_q & sda_i;
      blocking = (q.rst_stage == RS_BLOCK);
      dev_addr = {DEV_ADDR_HI, addr_sel_i};
      rd = reg_read(q.ptr, q);
      track_tick = 1'b0;
      neg_step = 1'b0;
      pos_step = 1'b0;
      need = {1'b0, q.limit} + 6'h01;
      det_next = q.detect;

      // Serial slave
      if (start_c) begin
         n.ist = I_RX;
         n.stage = STG_DEV;
         n.bit_cnt = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop_c) begin
         n.ist = I_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         unique case (q.ist)
            I_IDLE: begin
               n.sda_oe = 1'b0;
            end
            I_RX: begin
               if (scl_rise) begin
                  n.shift = {q.shift[6:0], sda_i};
                  n.bit_cnt = q.bit_cnt + 4'h1;
               end else if (scl_fall && q.bit_cnt == 4'h8) begin
                  n.bit_cnt = 4'h0;
                  n.ist = I_ACK;
                  n.sda_oe = 1'b1;
                  unique case (q.stage)
                     STG_DEV: begin
                        if (q.shift[7:1] != dev_addr || blocking) begin
                           n.ist = I_IDLE;
                           n.sda_oe = 1'b0;
                        end else begin
                           n.rw = q.shift[0];
                           n.stage = q.shift[0] ? STG_DATA : STG_REG;
                        end
                     end
                     STG_REG: begin
                        n.ptr = q.shift;
                        n.stage = STG_DATA;
                     end
                     default: begin
                        if (blocking) begin
                           n.ist = I_IDLE;
                           n.sda_oe = 1'b0;
                        end else begin
                           if (q.ptr != REG_LAST) begin
                              n.ptr = q.ptr + 8'h01;
                           end
                           unique case (q.ptr)
                              REG_RECAL: begin
                                 n.recal = q.shift;
                                 n.recal_start = (q.shift != 8'h00);
                              end
                              REG_SOFT_RST: begin
                                 n.soft_rst = q.shift;
                                 if (q.shift != 8'h00 && q.rst_stage == RS_NONE) begin
                                    n.rst_stage = RS_ARMED;
                                 end
                              end
                              REG_SLEEP: n.sleep = q.shift;
                              REG_BURST: n.burst = q.shift[BURST_W-1:0];
                              REG_NEG_RATE: n.neg_rate = q.shift[RATE_W-1:0];
                              REG_POS_RATE: n.pos_rate = q.shift[RATE_W-1:0];
                              REG_LIMIT: n.limit = q.shift[LIMIT_W-1:0];
                              default: n.recal = q.recal;
                           endcase
                        end
                     end
                  endcase
               end
            end
            I_ACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.ist = I_RX;
                  if (q.rw) begin
                     // Load next byte; reading a status byte releases its change flag
                     n.shift = rd;
                     n.sda_oe = ~rd[7];
                     n.bit_cnt = 4'h0;
                     n.ist = I_TX;
                     if (q.ptr != REG_LAST) begin
                        n.ptr = q.ptr + 8'h01;
                     end
                     if (q.ptr >= REG_KEY_LO && q.ptr <= REG_INPUTS) begin
                        n.changed[q.ptr[1:0] + 2'h1] = 1'b0;
                     end
                  end
               end
            end
            I_TX: begin
               if (scl_rise) begin
                  n.bit_cnt = q.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (q.bit_cnt == 4'h8) begin
                     n.sda_oe = 1'b0;
                     n.ist = I_HACK;
                  end else begin
                     n.shift = {q.shift[6:0], 1'b0};
                     n.sda_oe = ~q.shift[6];
                  end
               end
            end
            I_HACK: begin
               if (scl_rise) begin
                  n.ist = sda_i ? I_IDLE : I_ACK;
               end
            end
            default: n.ist = I_IDLE;
         endcase
      end

      // Measurement cycle timing
      if (cycle_tick) begin
         n.gpio = gpio_level_i & ~gpio_is_output_i;
         if (n.gpio != q.gpio) begin
            n.changed[3] = 1'b1;
         end
         if (q.sleep == 8'h00) begin
            n.sleep_cnt = 8'h00;
         end else if (q.sleep_cnt + 8'h01 >= q.sleep) begin
            n.sleep_cnt = 8'h00;
            n.meas_start = (n.sleep != 8'h00);
         end else begin
            n.sleep_cnt = q.sleep_cnt + 8'h01;
         end
         track_tick = (q.track_div == 4'(TRACK_DIV - 1));
         n.track_div = track_tick ? 4'h0 : q.track_div + 4'h1;
      end

      // Drift tracking rate counters
      if (track_tick) begin
         if (q.neg_rate == '0) begin
            n.neg_cnt = '0;
         end else if (q.neg_cnt + 7'h01 >= q.neg_rate) begin
            n.neg_cnt = '0;
            neg_step = 1'b1;
         end else begin
            n.neg_cnt = q.neg_cnt + 7'h01;
         end
         if (q.pos_rate == '0) begin
            n.pos_cnt = '0;
         end else if (q.pos_cnt + 7'h01 >= q.pos_rate) begin
            n.pos_cnt = '0;
            pos_step = 1'b1;
         end else begin
            n.pos_cnt = q.pos_cnt + 7'h01;
         end
      end
      // One-level reference steps; threshold recompute follows each step
      n.ref_down = {KEYS{neg_step}} & ~q.detect & ~key_over_thr_i & key_below_ref_i;
      n.ref_up = {KEYS{pos_step}} & ~q.detect & ~key_over_thr_i & key_above_ref_i;

      // Detection integrators and slider capture
      if (acq_done_i) begin
         for (int k = 0; k < KEYS; k++) begin
            if (key_over_thr_i[k]) begin
               if (q.di_cnt[k] < need) begin
                  n.di_cnt[k] = q.di_cnt[k] + 6'h01;
               end
               det_next[k] = (n.di_cnt[k] >= need);
            end else begin
               n.di_cnt[k] = '0;
               det_next[k] = 1'b0;
            end
         end
         n.detect = det_next;
         n.slider = slider_pos_i;
         if (det_next[7:0] != q.detect[7:0]) begin
            n.changed[0] = 1'b1;
         end
         if (det_next[15:8] != q.detect[15:8]) begin
            n.changed[1] = 1'b1;
         end
         if (slider_pos_i != q.slider) begin
            n.changed[2] = 1'b1;
         end
      end

      // Commanded reset: block the link for one cycle, then restore defaults
      if (cycle_tick && q.rst_stage == RS_ARMED) begin
         n.rst_stage = RS_BLOCK;
      end else if (cycle_tick && blocking) begin
         n = reset_state();
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= reset_state();
      end else begin
         q <= n;
      end
   end

   // ========================================================================
   // Outputs
   assign sda_o = 1'b0;
   assign sda_oe_o = q.sda_oe;
   assign change_n_o = 1'b0;
   assign change_oe_o = (|q.changed) & (q.rst_stage != RS_BLOCK);
   assign meas_start_o = q.meas_start;
   assign low_power_o = (q.sleep == 8'h00);
   assign burst_repeat_count_o = q.burst;
   assign recal_start_o = q.recal_start;
   assign ref_up_o = q.ref_up;
   assign ref_down_o = q.ref_down;

endmodule : touch_key_status_and_tuning

`default_nettype wire

// File: touch_key_properties.sv
// Port-level checks of the touch-key status and tuning block
`timescale 1ns/10ps
`default_nettype none
module touch_key_properties
   import touch_key_pkg::*;
#(
   parameter int unsigned CYCLE_CLKS_P = CYCLE_CLKS
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Watched outputs
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic change_n_o,
   input wire logic change_oe_o,
   input wire logic meas_start_o,
   input wire logic low_power_o,
   input wire logic [BURST_W-1:0] burst_repeat_count_o,
   input wire logic recal_start_o,
   input wire logic [KEYS-1:0] ref_up_o,
   input wire logic [KEYS-1:0] ref_down_o
);
   // ======================================================================
   // Clocks since the last burst start and last drift step
   logic [31:0] meas_gap_q;
   logic [31:0] step_gap_q;
   function automatic logic [31:0] inc(input logic [31:0] v);
      return v + 32'(v < 32'h00ffffff);
   endfunction : inc
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meas_gap_q <= 32'h00ffffff;
         step_gap_q <= 32'h00ffffff;
      end else begin
         meas_gap_q <= meas_start_o ? 32'h00000000 : inc(meas_gap_q);
         step_gap_q <= |(ref_up_o | ref_down_o) ? 32'h00000000 : inc(step_gap_q);
      end
   end

   // ======================================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_drive_low;
      change_n_o == 1'b0 && sda_o == 1'b0;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("open-drain drive value not low");
   property p_reset_out;
      $rose(rst_b_i) |-> !change_oe_o && !sda_oe_o && burst_repeat_count_o == 6'h01;
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("outputs wrong after reset");
   property p_reset_lp;
      $rose(rst_b_i) |-> !low_power_o;
   endproperty
   a_reset_lp: assert property (p_reset_lp)
      else $error("low power active after reset");
   property p_lp_no_meas;
      low_power_o |-> !meas_start_o;
   endproperty
   a_lp_no_meas: assert property (p_lp_no_meas)
      else $error("burst started in low power");
   property p_meas_gap;
      meas_start_o |-> meas_gap_q >= CYCLE_CLKS_P - 1;
   endproperty
   a_meas_gap: assert property (p_meas_gap)
      else $error("bursts closer than one cycle");
   property p_recal_pulse;
      recal_start_o |=> !recal_start_o;
   endproperty
   a_recal_pulse: assert property (p_recal_pulse)
      else $error("recalibration pulse too long");
   property p_ref_dir;
      (ref_up_o & ref_down_o) == '0;
   endproperty
   a_ref_dir: assert property (p_ref_dir)
      else $error("reference moved both ways");
   property p_step_gap;
      |(ref_up_o | ref_down_o) |-> step_gap_q >= CYCLE_CLKS_P - 1;
   endproperty
   a_step_gap: assert property (p_step_gap)
      else $error("drift steps closer than one cycle");
endmodule : touch_key_properties
`default_nettype wire

// File: touch_key_host.sv
// Host model driving the serial register link
`timescale 1ns/10ps
`default_nettype none
module touch_key_host #(
   parameter logic [6:0] DEV_P = 7'h0d
) (
   // Clock and wire level
   input wire logic ref_clk_i,
   input wire logic sda_i,
   // Host drive and read result
   output logic scl_o,
   output logic sda_pull_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : hold
   task automatic put_bit(input logic b);
      sda_pull_o = !b;
      hold(1);
      scl_o = 1'b1;
      hold(2);
      scl_o = 1'b0;
      hold(1);
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_pull_o = 1'b0;
      hold(1);
      scl_o = 1'b1;
      hold(1);
      b = sda_i;
      hold(1);
      scl_o = 1'b0;
      hold(1);
   endtask : get_bit
   task automatic start();
      hold(2);
      sda_pull_o = 1'b1;
      hold(2);
      scl_o = 1'b0;
      hold(1);
   endtask : start
   task automatic stop();
      sda_pull_o = 1'b1;
      hold(1);
      scl_o = 1'b1;
      hold(2);
      sda_pull_o = 1'b0;
      hold(2);
   endtask : stop
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = !b;
   endtask : byte_out
   task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      if (r == 8'h0d && d[5:0] == 6'h00) d = 8'h01;
      start();
      byte_out({DEV_P, 1'b0}, a0);
      byte_out(r, a1);
      byte_out(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : wr
   task automatic rd(input logic [7:0] r, input int n);
      logic a;
      logic [7:0] d;
      start();
      byte_out({DEV_P, 1'b0}, a);
      byte_out(r, a);
      stop();
      start();
      byte_out({DEV_P, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         for (int j = 7; j >= 0; j--) get_bit(d[j]);
         put_bit(i == n - 1);
         rd_data_o = d;
         rd_valid_o = 1'b1;
         hold(1);
         rd_valid_o = 1'b0;
      end
      stop();
   endtask : rd
endmodule : touch_key_host
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the touch-key status and tuning block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import touch_key_pkg::*;
   localparam int unsigned CYC = 200;
   logic clk, rst_b, scl, sda_pull, sda, acq, rd_valid, ok;
   logic sda_drv, sda_oe, chg_n, chg_oe, meas, lp, recal;
   logic [7:0] slider, rd_data, gexp;
   logic [15:0] k;
   logic [KEYS-1:0] over, above, below, up, down;
   logic [GPIO_N-1:0] gpio_lvl, gpio_out;
   logic [BURST_W-1:0] burst;
   logic [7:0] q[$];
   integer seed = 32'hfb91570c;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int recal_cnt = 0;
   int up_cnt = 0;
   int down_cnt = 0;
   int n, u, c0;
   assign sda = !(sda_pull | sda_oe);
   touch_key_status_and_tuning #(.CYCLE_CLKS_P(CYC)) dut (
      .ref_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
      .sda_oe_o(sda_oe), .addr_sel_i(2'b01), .change_n_o(chg_n), .change_oe_o(chg_oe),
      .acq_done_i(acq), .key_over_thr_i(over), .key_above_ref_i(above),
      .key_below_ref_i(below), .slider_pos_i(slider), .gpio_level_i(gpio_lvl),
      .gpio_is_output_i(gpio_out), .meas_start_o(meas), .low_power_o(lp),
      .burst_repeat_count_o(burst), .recal_start_o(recal), .ref_up_o(up), .ref_down_o(down));
   touch_key_host #(.DEV_P(7'h0d)) host (.ref_clk_i(clk), .sda_i(sda), .scl_o(scl),
      .sda_pull_o(sda_pull), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
   always #2 clk = ~clk;
   task automatic end_sim;
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : settle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d, ok);
      check({15'h0, ok}, 16'h0001);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e[$]);
      foreach (e[i]) q.push_back(e[i]);
      host.rd(a, e.size());
   endtask : rd_chk
   task automatic wait_meas(output int c);
      c = 0;
      do begin
         settle(1);
         c++;
      end while (meas !== 1'b1 && c < 1000);
   endtask : wait_meas
   task automatic acq_run(input logic [15:0] o);
      over = o;
      slider = 8'($random(seed));
      acq = 1'b1;
      settle(1);
      acq = 1'b0;
   endtask : acq_run
   // Result watcher and hang limit
   always @(posedge clk) begin
      cycles++;
      if (recal === 1'b1) recal_cnt++;
      if (up[0] === 1'b1) up_cnt++;
      if (down[1] === 1'b1) down_cnt++;
      if (rd_valid === 1'b1) check({8'h00, rd_data}, {8'h00, q.pop_front()});
      if (cycles == 40000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      clk = 1'b0; rst_b = 1'b0; acq = 1'b0; over = '0; above = '0; below = '0;
      slider = 8'h00; gpio_lvl = '0; gpio_out = '0;
      settle(3);
      rst_b = 1'b1;
      settle(2);
      rd_chk(REG_SLEEP, '{8'h01, 8'h01, 8'h00, 8'h14, 8'h05, 8'h03});
      rd_chk(REG_SUBREV, '{SUB_REVISION});
      check({10'h0, burst}, 16'h0001);
      for (int a = 12; a < 18; a++) wr(8'(a), a == 14 ? 8'h00 : 8'hff);
      rd_chk(REG_SLEEP, '{8'hff, 8'h3f, 8'h00, 8'h7f, 8'h7f, 8'h1f});
      check({10'h0, burst}, 16'h003f);
      wr(REG_SLEEP, 8'h00);
      check({15'h0, lp}, 16'h0001);
      wait_meas(n);
      check(16'(n), 16'h03e8);
      wr(REG_SLEEP, 8'h02);
      wait_meas(n);
      wait_meas(n);
      check(16'(n), 16'(2 * CYC));
      // Drift tracking upward on one key and downward on another
      above[0] = 1'b1;
      below[1] = 1'b1;
      wr(REG_POS_RATE, 8'h01);
      wr(REG_NEG_RATE, 8'h01);
      u = up_cnt;
      c0 = down_cnt;
      settle(10 * CYC + 100);
      check({15'h0, up_cnt > u}, 16'h0001);
      check({15'h0, down_cnt > c0}, 16'h0001);
      wr(REG_POS_RATE, 8'h00);
      wr(REG_NEG_RATE, 8'h00);
      u = up_cnt;
      c0 = down_cnt;
      settle(10 * CYC + 100);
      check(16'(up_cnt - u), 16'h0000);
      check(16'(down_cnt - c0), 16'h0000);
      above[0] = 1'b0;
      below[1] = 1'b0;
      u = recal_cnt;
      wr(REG_RECAL, 8'h00);
      check(16'(recal_cnt - u), 16'h0000);
      wr(REG_RECAL, 8'h5a);
      check(16'(recal_cnt - u), 16'h0001);
      rd_chk(REG_RECAL, '{8'h5a});
      for (int i = 0; i < 4; i++) begin
         gpio_lvl = 3'($random(seed));
         gpio_out = 3'($random(seed));
         gexp = {3'h0, gpio_lvl & ~gpio_out, 2'h0};
         settle(CYC + 5);
         rd_chk(REG_INPUTS, '{gexp});
      end
      // Detection integrator with limit one
      wr(REG_LIMIT, 8'h01);
      k = 16'($random(seed)) | 16'h8001;
      acq_run(k);
      acq_run(16'h0000);
      acq_run(k);
      rd_chk(REG_KEY_LO, '{8'h00, 8'h00, slider, gexp});
      acq_run(k);
      settle(2);
      check({15'h0, chg_oe}, 16'h0001);
      rd_chk(REG_KEY_LO, '{k[7:0], k[15:8], slider, gexp});
      check({15'h0, chg_oe}, 16'h0000);
      // Soft reset, timed from a burst start
      wr(REG_SLEEP, 8'h01);
      wait_meas(n);
      c0 = cycles;
      acq_run(16'h0000);
      wr(REG_SOFT_RST, 8'h01);
      while (cycles < c0 + CYC + 30) settle(1);
      check({15'h0, chg_oe}, 16'h0000);
      host.wr(REG_SLEEP, 8'h07, ok);
      check({15'h0, ok}, 16'h0000);
      while (cycles < c0 + 2 * CYC + 40) settle(1);
      rd_chk(REG_KEY_LO, '{8'h00, 8'h00});
      rd_chk(REG_SLEEP, '{8'h01, 8'h01, 8'h00, 8'h14, 8'h05, 8'h03});
      settle(5);
      end_sim();
   end
endmodule : testbench
bind touch_key_status_and_tuning touch_key_properties #(.CYCLE_CLKS_P(CYCLE_CLKS_P)) props (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .change_n_o(change_n_o), .change_oe_o(change_oe_o), .meas_start_o(meas_start_o),
   .low_power_o(low_power_o), .burst_repeat_count_o(burst_repeat_count_o),
   .recal_start_o(recal_start_o), .ref_up_o(ref_up_o), .ref_down_o(ref_down_o));
`default_nettype wire
